// ==== shared/rps_defs.svh ====
// Constants of the register-pointer I2C target port
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// ==========================================================
// Addressing
`define RPS_TARGET_ADDR 7'h32
`define RPS_PTR_RESET 8'h00
`define RPS_PTR_LAST 8'hFF
`define RPS_SCRATCH_FIRST 8'h88
`define RPS_SCRATCH_LAST 8'h8B
`define RPS_SCRATCH_RESET 8'h00
`define RPS_UNMAPPED_READ 8'h00

// ==========================================================
// Bit slots within one nine-clock byte frame
`define RPS_LAST_BIT 4'h7
`define RPS_ACK_SLOT 4'h8

// ==========================================================
// Timing: link clear pulse, longest time so rounded down
`define RPS_CLK_PERIOD_NS 50
`define RPS_CLEAR_NS 200
`define RPS_CLEAR_CYC (`RPS_CLEAR_NS / `RPS_CLK_PERIOD_NS)

`endif

// ==== shared/rps_pkg.sv ====
// Types shared by the register-pointer I2C target port
`default_nettype none

package rps_pkg;

    // ======================================================
    // Link-side frame sequencer states
    typedef enum logic [4:0] {
        LS_IDLE   = 5'b00001,
        LS_ADDR   = 5'b00010,
        LS_WDATA  = 5'b00100,
        LS_RDATA  = 5'b01000,
        LS_IGNORE = 5'b10000
    } rps_link_state_type;

    // Frame state, cleared at every START and STOP
    typedef struct packed {
        rps_link_state_type state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic sda_low;
        logic first;
    } rps_frame_type;

    // Event state, survives START and STOP so toggles never glitch
    typedef struct packed {
        logic wr_tog;
        logic wr_is_ptr;
        logic [7:0] wr_byte;
        logic rd_tog;
    } rps_event_type;

    // System-side state
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [2:0] wr_sync;
        logic [2:0] rd_sync;
        logic [2:0] clr_cnt;
        logic link_clear;
        logic [7:0] ptr;
        logic [3:0][7:0] scratch;
        logic [7:0] rd_byte;
    } rps_sys_type;

endpackage

`default_nettype wire

// ==== rtl/rps_link.sv ====
// Bit engine of the I2C target, clocked by SCL itself
`default_nettype none
`include "rps_defs.svh"

module rps_link
    import rps_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = `RPS_TARGET_ADDR
) (
    // Link clock and resets
    input wire logic scl_clk_in,
    input wire logic resetn_in,
    input wire logic frame_clear_in,
    // Pin
    input wire logic sda_in,
    output logic sda_oe_n_out,
    // Events toward the system domain
    output logic wr_tog_out,
    output logic wr_is_ptr_out,
    output logic [7:0] wr_byte_out,
    output logic rd_tog_out,
    // Byte at the pointer, quasi-static
    input wire logic [7:0] rd_byte_in
);

    rps_frame_type f;
    rps_frame_type next_f;
    rps_event_type e;
    rps_event_type next_e;
    logic sda_smp;
    logic frame_rst;

    // Frame state dies on reset or on a START/STOP seen by the system side
    assign frame_rst = ~resetn_in | frame_clear_in;

    // ==========================================================
    // Receive sampling on the rising edge, as the bus demands
    always_ff @(posedge scl_clk_in or posedge frame_rst) begin
        if (frame_rst) begin
            sda_smp <= 1'b1;
        end else begin
            sda_smp <= sda_in;
        end
    end

    // ==========================================================
    // Frame sequencer; everything moves on the falling edge
    always_comb begin
        next_f = f;
        next_e = e;
        unique case (f.state)
            LS_IDLE: begin
                // First fall after START holds no bit yet
                next_f.state = LS_ADDR;
                next_f.cnt = 4'h0;
            end
            LS_ADDR, LS_WDATA: begin
                if (f.cnt == `RPS_ACK_SLOT) begin
                    next_f.sda_low = 1'b0;
                    next_f.cnt = 4'h0;
                    if (f.state == LS_ADDR && f.rw) begin
                        next_f.state = LS_RDATA;
                        next_f.shift = rd_byte_in;
                        next_f.sda_low = ~rd_byte_in[7];
                    end else begin
                        next_f.state = LS_WDATA;
                    end
                end else begin
                    next_f.shift = {f.shift[6:0], sda_smp};
                    next_f.cnt = f.cnt + 4'h1;
                    if (f.cnt == `RPS_LAST_BIT) begin
                        if (f.state == LS_ADDR) begin
                            if (f.shift[6:0] == TARGET_ADDR) begin
                                next_f.sda_low = 1'b1;
                                next_f.rw = sda_smp;
                            end else begin
                                next_f.state = LS_IGNORE;
                            end
                        end else begin
                            // First byte is the pointer, later ones data
                            next_f.sda_low = 1'b1;
                            next_e.wr_tog = ~e.wr_tog;
                            next_e.wr_is_ptr = f.first;
                            next_e.wr_byte = {f.shift[6:0], sda_smp};
                            next_f.first = 1'b0;
                        end
                    end
                end
            end
            LS_RDATA: begin
                if (f.cnt == `RPS_ACK_SLOT) begin
                    next_f.cnt = 4'h0;
                    if (!sda_smp) begin
                        next_f.shift = rd_byte_in;
                        next_f.sda_low = ~rd_byte_in[7];
                    end else begin
                        // Controller NACK ends the burst
                        next_f.state = LS_IGNORE;
                        next_f.sda_low = 1'b0;
                    end
                end else begin
                    next_f.cnt = f.cnt + 4'h1;
                    if (f.cnt == `RPS_LAST_BIT) begin
                        // Release for the ACK; a whole clock is left to step
                        next_f.sda_low = 1'b0;
                        next_e.rd_tog = ~e.rd_tog;
                    end else begin
                        next_f.shift = {f.shift[6:0], 1'b0};
                        next_f.sda_low = ~f.shift[6];
                    end
                end
            end
            LS_IGNORE: begin
                next_f.sda_low = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Frame registers
    always_ff @(negedge scl_clk_in or posedge frame_rst) begin
        if (frame_rst) begin
            f <= '{state: LS_IDLE, cnt: 4'h0, shift: 8'h00, rw: 1'b0,
                   sda_low: 1'b0, first: 1'b1};
        end else begin
            f <= next_f;
        end
    end

    // Event registers
    always_ff @(negedge scl_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            e <= '0;
        end else begin
            e <= next_e;
        end
    end

    assign sda_oe_n_out = ~f.sda_low;
    assign wr_tog_out = e.wr_tog;
    assign wr_is_ptr_out = e.wr_is_ptr;
    assign wr_byte_out = e.wr_byte;
    assign rd_tog_out = e.rd_tog;

    // ==========================================================
    // Checks on the address phase
    AST_ADDR_MISS: assert property (@(negedge scl_clk_in)
        disable iff (frame_rst)
        (f.state == LS_ADDR && f.cnt == 4'h7 &&
         f.shift[6:0] != TARGET_ADDR) |=>
        (f.state == LS_IGNORE && !f.sda_low) [*2])
        else $error("foreign address not ignored");

    // A read keeps SDA low past the ACK when its first bit is zero
    AST_ADDR_HIT: assert property (@(negedge scl_clk_in)
        disable iff (frame_rst)
        (f.state == LS_ADDR && f.cnt == 4'h7 &&
         f.shift[6:0] == TARGET_ADDR) |=> f.sda_low ##1
        (f.state == LS_RDATA || !f.sda_low))
        else $error("own address not acknowledged for one clock");

endmodule // rps_link

`default_nettype wire

// ==== rtl/rps_top.sv ====
// Register-pointer I2C target port with its register bank
`default_nettype none
`include "rps_defs.svh"

module rps_top
    import rps_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = `RPS_TARGET_ADDR
) (
    // System clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // I2C pins, SCL is also the link clock
    input wire logic link_scl_clk_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out
);

    rps_sys_type s;
    rps_sys_type next_s;
    logic start_det;
    logic stop_det;
    logic wr_ev;
    logic rd_ev;
    logic link_wr_tog;
    logic link_wr_is_ptr;
    logic [7:0] link_wr_byte;
    logic link_rd_tog;
    logic ptr_in_scratch;
    logic [1:0] ptr_idx;

    // ==========================================================
    // Bit engine on the SCL clock
    // Crossing scheme: the link flips a toggle on the SCL fall that
    // ends a byte, and only that toggle passes two flops here.
    // Byte values ride beside it and are read while the link holds
    // them for a whole byte time; the read byte goes the other way
    // and has settled long before the next SCL fall needs it.
    // Limitation: SCL must stay far slower than ref_clk for this.
    rps_link #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_link (
        .scl_clk_in(link_scl_clk_in),
        .resetn_in(resetn_in),
        .frame_clear_in(s.link_clear),
        .sda_in(sda_in),
        .sda_oe_n_out(sda_oe_n_out),
        .wr_tog_out(link_wr_tog),
        .wr_is_ptr_out(link_wr_is_ptr),
        .wr_byte_out(link_wr_byte),
        .rd_tog_out(link_rd_tog),
        .rd_byte_in(s.rd_byte)
    );

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;

    // ==========================================================
    // Bus conditions and event edges, read past the first sync stage
    assign start_det = s.scl_sync[1] & s.scl_sync[2] &
                       s.sda_sync[2] & ~s.sda_sync[1];
    assign stop_det = s.scl_sync[1] & s.scl_sync[2] &
                      ~s.sda_sync[2] & s.sda_sync[1];
    assign wr_ev = s.wr_sync[2] ^ s.wr_sync[1];
    assign rd_ev = s.rd_sync[2] ^ s.rd_sync[1];

    // Scratch window decode; base is word aligned so low bits index it
    assign ptr_in_scratch = (s.ptr >= `RPS_SCRATCH_FIRST) &&
                            (s.ptr <= `RPS_SCRATCH_LAST);
    assign ptr_idx = s.ptr[1:0];

    // ==========================================================
    // System-side next state
    always_comb begin
        next_s = s;
        // Two-stage synchronisers plus one stage for edge detection
        next_s.scl_sync = {s.scl_sync[1:0], link_scl_clk_in};
        next_s.sda_sync = {s.sda_sync[1:0], sda_in};
        next_s.wr_sync = {s.wr_sync[1:0], link_wr_tog};
        next_s.rd_sync = {s.rd_sync[1:0], link_rd_tog};

        // Short clear pulse: it must end before the first SCL fall
        // after START, which is what bounds the Fast Mode margin
        if (start_det || stop_det) begin
            next_s.link_clear = 1'b1;
            next_s.clr_cnt = 3'(`RPS_CLEAR_CYC - 1);
        end else if (s.clr_cnt != 3'h0) begin
            next_s.clr_cnt = s.clr_cnt - 3'h1;
        end else begin
            next_s.link_clear = 1'b0;
        end

        // Written byte: held stable by the link for a whole byte time
        if (wr_ev) begin
            if (link_wr_is_ptr) begin
                next_s.ptr = link_wr_byte;
            end else begin
                for (int i = 0; i < 4; i++) begin
                    if (ptr_in_scratch && ptr_idx == 2'(i)) begin
                        next_s.scratch[i] = link_wr_byte;
                    end
                end
                next_s.ptr = s.ptr + 8'h01;
            end
        end

        // Byte sent: step on to the next register
        if (rd_ev) begin
            next_s.ptr = s.ptr + 8'h01;
        end

        // Read byte for the current pointer; unmapped reads as zero
        if (ptr_in_scratch) begin
            next_s.rd_byte = s.scratch[ptr_idx];
        end else begin
            next_s.rd_byte = `RPS_UNMAPPED_READ;
        end
    end

    // ==========================================================
    // System-side registers; scratch content is lost only at reset
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s.scl_sync <= 3'h7;
            s.sda_sync <= 3'h7;
            s.wr_sync <= 3'h0;
            s.rd_sync <= 3'h0;
            s.clr_cnt <= 3'h0;
            s.link_clear <= 1'b0;
            s.ptr <= `RPS_PTR_RESET;
            s.scratch <= {4{`RPS_SCRATCH_RESET}};
            s.rd_byte <= `RPS_UNMAPPED_READ;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_CLEAR_LEN: assert property (
        $rose(s.link_clear) |-> s.link_clear [*4] ##1 !s.link_clear)
        else $error("link clear pulse length wrong");

    AST_PTR_LOAD: assert property (
        (wr_ev && link_wr_is_ptr) |=> s.ptr == $past(link_wr_byte))
        else $error("pointer not loaded from first written byte");

    AST_PTR_INC_WR: assert property (
        (wr_ev && !link_wr_is_ptr) |=> s.ptr == 8'($past(s.ptr) + 1))
        else $error("pointer did not step after data write");

    AST_PTR_INC_RD: assert property (
        rd_ev |=> s.ptr == 8'($past(s.ptr) + 1))
        else $error("pointer did not step after byte sent");

    AST_PTR_WRAP: assert property (
        ((rd_ev || (wr_ev && !link_wr_is_ptr)) && s.ptr == 8'hFF)
        |=> s.ptr == 8'h00)
        else $error("pointer did not wrap to zero");

    AST_SCRATCH_WR: assert property (
        (wr_ev && !link_wr_is_ptr && ptr_in_scratch) |=>
        s.scratch[$past(ptr_idx)] == $past(link_wr_byte))
        else $error("scratch register did not store byte");

    AST_RD_SCRATCH: assert property (
        (ptr_in_scratch && !wr_ev) ##1 $stable(s.ptr) |=>
        s.rd_byte == $past(s.scratch[ptr_idx], 2))
        else $error("read byte does not follow pointer");

    AST_RD_UNMAPPED: assert property (
        !ptr_in_scratch |=> s.rd_byte == 8'h00)
        else $error("unmapped register did not read zero");

    // ==========================================================
    // Checks on bus conditions and on state that must not move
    // A missed condition would leave the link in a stale frame
    AST_START_CLEAR: assert property (
        start_det |=> s.link_clear)
        else $error("START did not open a clear pulse");

    AST_STOP_CLEAR: assert property (
        stop_det |=> s.link_clear)
        else $error("STOP did not open a clear pulse");

    // While the frame is cleared the target must let SDA go
    AST_CLEAR_RELEASE: assert property (
        s.link_clear |-> sda_oe_n_out)
        else $error("SDA still pulled during frame clear");

    // A stray step would shift every later byte of a burst
    AST_PTR_HOLD: assert property (
        !(wr_ev || rd_ev) |=> $stable(s.ptr))
        else $error("pointer moved without a byte event");

    // Each toggle must give one event, or a byte counts twice
    AST_EV_SINGLE: assert property (
        (wr_ev || rd_ev) |=> !(wr_ev || rd_ev))
        else $error("byte event lasted more than one clock");

    // Writes outside the window are dropped, not stored
    AST_SCRATCH_HOLD: assert property (
        !(wr_ev && !link_wr_is_ptr && ptr_in_scratch) |=>
        $stable(s.scratch))
        else $error("scratch changed without a write to it");

endmodule // rps_top

`default_nettype wire

// ==== tb/rps_host.sv ====
// Bus controller model driving the target port from the far side
`default_nettype none

module rps_host (
    // Bench clock, used only as a time base
    input wire logic clk_in,
    // Resolved data wire
    input wire logic sda_in,
    // Controller pins
    output logic scl_out,
    output logic sda_oe_n_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Half SCL period in bench cycles: 25 is 400 kHz, 100 is 100 kHz
    int half_cyc = 25;

    // Bus idle: clock high, data released to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // START, or repeated START when the clock is low; long hold time
    task automatic start_cond();
        sda_oe_n_out = 1'b1;
        idle(half_cyc);
        scl_out = 1'b1;
        idle(half_cyc);
        sda_oe_n_out = 1'b0;
        idle(half_cyc);
        scl_out = 1'b0;
        idle(2);
    endtask

    task automatic stop_cond();
        sda_oe_n_out = 1'b0;
        idle(half_cyc);
        scl_out = 1'b1;
        idle(half_cyc);
        sda_oe_n_out = 1'b1;
        idle(2 * half_cyc);
    endtask

    // Data moves only while clock is low, two cycles after its fall
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n_out = b;
        idle(half_cyc - 2);
        scl_out = 1'b1;
        idle(half_cyc / 2);
        r = sda_in;
        idle(half_cyc - half_cyc / 2);
        scl_out = 1'b0;
        idle(2);
    endtask

    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic byte_rx(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule // rps_host

`default_nettype wire

// ==== tb/rps_top_tb.sv ====
// Self-checking bench of the register-pointer target port
`default_nettype none
`include "rps_defs.svh"

module rps_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Clock, reset, wires and model state
    localparam int MAX_CYC = 110000;
    logic ref_clk = 1'b0;
    logic resetn = 1'b1; // Falls at the first negedge: a real edge
    logic scl;
    logic h_oe_n;
    logic d_sda;
    logic d_oe_n;
    logic sda_bus;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int ptr = 0;
    int seed_v;
    logic [7:0] scr [4] = '{default: 8'h00};

    always #25 ref_clk = ~ref_clk;

    // Open-drain wire with pull-up: low whenever any party pulls
    assign sda_bus = h_oe_n & (d_oe_n | d_sda);

    rps_top i_dut (
        .ref_clk_in(ref_clk),
        .resetn_in(resetn),
        .link_scl_clk_in(scl),
        .sda_in(sda_bus),
        .sda_out(d_sda),
        .sda_oe_n_out(d_oe_n)
    );

    rps_host i_host (
        .clk_in(ref_clk),
        .sda_in(sda_bus),
        .scl_out(scl),
        .sda_oe_n_out(h_oe_n)
    );

    // ==========================================================
    // Model and checking helpers
    function automatic logic [7:0] mexp(input int p);
        if (p >= 8'h88 && p <= 8'h8B) begin
            return scr[p - 8'h88];
        end
        return 8'h00;
    endfunction

    task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tx(input logic [7:0] d, input logic exp_ack);
        logic ack;
        i_host.byte_tx(d, ack);
        check8({7'h00, ack}, {7'h00, exp_ack}, "ack");
    endtask

    // Address+W, pointer, then n random bytes; no STOP so Sr may follow
    task automatic wr(input logic [7:0] p, input int n);
        logic [7:0] d;
        i_host.start_cond();
        tx({`RPS_TARGET_ADDR, 1'b0}, 1'b1);
        tx(p, 1'b1);
        ptr = p;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            tx(d, 1'b1);
            if (ptr >= 8'h88 && ptr <= 8'h8B) begin
                scr[ptr - 8'h88] = d;
            end
            ptr = (ptr + 1) % 256;
        end
    endtask

    // Read n bytes from the model pointer, NACK the last, then STOP
    task automatic rd(input int n);
        logic [7:0] d;
        i_host.start_cond();
        tx({`RPS_TARGET_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_host.byte_rx(d, i == n - 1);
            check8(d, mexp(ptr), "read byte");
            ptr = (ptr + 1) % 256;
        end
        i_host.stop_cond();
    endtask

    task automatic done_test(input string s);
        $display("test %s finished", s);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard: the long wrap read dominates the run time
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            n_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            give_verdict();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed_v = $urandom(39);
        @(negedge ref_clk);
        resetn = 1'b0;
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        wr(8'h88, 0);
        rd(4);
        done_test("reset values");
        // Burst from an unmapped place across all four scratch bytes
        wr(8'h87, 6);
        i_host.stop_cond();
        wr(8'h87, 0);
        rd(6);
        done_test("burst write");
        // Repeated START inside a write makes the next byte a pointer
        wr(8'h89, 1);
        wr(8'h8A, 1);
        i_host.stop_cond();
        wr(8'h89, 0);
        rd(2);
        done_test("write restart");
        // Foreign address: no ACK, pointer and data untouched
        i_host.start_cond();
        tx({`RPS_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b0);
        tx(8'h88, 1'b0);
        tx(8'hEE, 1'b0);
        i_host.stop_cond();
        rd(1);
        done_test("foreign address");
        // Standard Mode clock rate
        i_host.half_cyc = 100;
        wr(8'h88, 2);
        rd(2);
        i_host.half_cyc = 25;
        done_test("standard mode");
        // Power cycle after scratch use clears the registers
        resetn = 1'b0;
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        scr = '{default: 8'h00};
        repeat (4) @(negedge ref_clk);
        // Writes at FE, FF and 00 are dropped; read wraps back to 88
        wr(8'hFE, 3);
        i_host.stop_cond();
        wr(8'h88, 1);
        i_host.stop_cond();
        wr(8'hFF, 0);
        rd(138);
        done_test("pointer wrap");
        give_verdict();
    end
endmodule // rps_top_tb

`default_nettype wire
